// ---- rtl/pmbus_cfg_pkg.sv ----
`default_nettype none
package pmbus_cfg_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int CLK_KHZ = NS_PER_MS / CLK_PERIOD_NS;
	localparam int CYCLES_PER_MS = CLK_KHZ;
	// fixed-point carrier: volts, amps, percent, kHz with 11 fraction bits
	localparam int FIX_W = 32;
	localparam int FIX_FRAC = 11;
	localparam int VOUT_EXP_FIXED = -11;
	localparam int PER_W = 20;
	localparam int PCT_FULL = 100;
	localparam int MV_RECIP = 1049;
	localparam int MV_RECIP_SH = 20;
	// command codes
	localparam logic [7:0] CODE_MARGIN_DOWN = 8'h26;
	localparam logic [7:0] CODE_RAMP_RATE = 8'h27;
	localparam logic [7:0] CODE_SLOPE = 8'h28;
	localparam logic [7:0] CODE_FLOOR = 8'h2B;
	localparam logic [7:0] CODE_DUTY_MAX = 8'h32;
	localparam logic [7:0] CODE_SW_RATE = 8'h33;
	localparam logic [7:0] CODE_INPUT_TURN_ON_THRESHOLD = 8'h35;
	localparam logic [7:0] CODE_INPUT_TURN_OFF_THRESHOLD = 8'h36;
	localparam logic [7:0] CODE_SPREAD = 8'h37;
	localparam logic [7:0] CODE_CUR_OFFSET = 8'h39;
	localparam logic [7:0] CODE_OV_LEVEL = 8'h40;
	// output-voltage mode byte
	localparam int MODE_SEL_HI = 7;
	localparam int MODE_SEL_LO = 5;
	localparam int MODE_EXP_HI = 4;
	localparam int MODE_EXP_LO = 0;
	localparam logic [2:0] MODE_LINEAR = 3'h0;
	// linear word
	localparam int LIN_EXP_HI = 15;
	localparam int LIN_EXP_LO = 11;
	localparam int LIN_MAN_HI = 10;
	localparam int LIN_MAN_LO = 0;
	// interleave word
	localparam int GROUP_HI = 11;
	localparam int GROUP_LO = 8;
	localparam int COUNT_HI = 7;
	localparam int COUNT_LO = 4;
	localparam int POS_HI = 3;
	localparam int POS_LO = 0;
	localparam logic [3:0] POS_LEAD = 4'h0;
	localparam logic [3:0] COUNT_ONE = 4'h1;
	// reset value of every stored word
	localparam logic [15:0] RESET_WORD = 16'h0000;
	// target selection
	localparam logic [1:0] TGT_NOMINAL = 2'h0;
	localparam logic [1:0] TGT_HIGH = 2'h1;
	localparam logic [1:0] TGT_LOW = 2'h2;
	typedef enum logic [1:0] {
		CONV_IDLE = 2'b01,
		CONV_RUN = 2'b10
	} conv_state_e;
endpackage : pmbus_cfg_pkg
`default_nettype wire

// ---- rtl/pwm_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface pwm_if;
	logic [19:0] period;
	logic [19:0] on_time;
	logic [19:0] phase;
	logic run;
	logic lead;
	modport ctrl(output period, output on_time, output phase, output run,
		output lead);
	modport gen(input period, input on_time, input phase, input run,
		input lead);
endinterface : pwm_if
`default_nettype wire

// ---- rtl/pwm_gen.sv ----
`timescale 1ns/1ns
`default_nettype none
module pwm_gen (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	pwm_if.gen ctl,
	input wire logic sync_i,
	output logic pwm_o,
	output logic sync_out_o
);
	import pmbus_cfg_pkg::*;
	typedef struct packed {
		logic [19:0] cnt;
		logic pwm;
		logic sync_out;
	} gen_s;
	gen_s r_reg;
	gen_s r_next;
	always_comb begin
		r_next = r_reg;
		if (!ctl.run || ctl.period == '0) begin
			r_next.cnt = '0;
		end else if (sync_i && !ctl.lead) begin
			// follower realigns so its period starts phase cycles late
			r_next.cnt = (ctl.phase == '0) ? '0 : ctl.period - ctl.phase;
		end else if (r_reg.cnt + 20'h00001 >= ctl.period) begin
			r_next.cnt = '0;
		end else begin
			r_next.cnt = r_reg.cnt + 20'h00001;
		end
		r_next.pwm = ctl.run && (r_next.cnt < ctl.on_time);
		// only position zero sources the shared clock
		r_next.sync_out = ctl.run && ctl.lead && (r_next.cnt == '0);
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
	assign pwm_o = r_reg.pwm;
	assign sync_out_o = r_reg.sync_out;
endmodule : pwm_gen
`default_nettype wire

// ---- rtl/pmbus_output_config_commands.sv ----
`timescale 1ns/1ns
`default_nettype none
module pmbus_output_config_commands #(
	parameter int CYCLES_PER_MS_P = pmbus_cfg_pkg::CYCLES_PER_MS
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	output logic [15:0] cmd_rdata_o,
	output logic cmd_done_o,
	output logic cmd_unsupported_o,
	input wire logic [7:0] vout_mode_i,
	input wire logic [15:0] vout_command_i,
	input wire logic [15:0] vout_trim_i,
	input wire logic [15:0] margin_up_target_i,
	input wire logic [1:0] target_sel_i,
	input wire logic [15:0] vin_meas_i,
	input wire logic [15:0] iout_meas_i,
	input wire logic [15:0] vout_meas_i,
	input wire logic [15:0] duty_cmd_i,
	input wire logic clear_warning_i,
	input wire logic sync_i,
	output logic signed [31:0] vout_ref_o,
	output logic signed [31:0] iout_report_o,
	output logic floor_warning_o,
	output logic ov_fault_o,
	output logic converting_o,
	output logic [3:0] group_id_o,
	output logic pwm_o,
	output logic sync_out_o
);
	import pmbus_cfg_pkg::*;

	// ==================================================================
	// state
	typedef struct packed {
		logic [15:0] margin_down;
		logic [15:0] ramp_rate;
		logic [15:0] slope;
		logic [15:0] floor;
		logic [15:0] duty_max;
		logic [15:0] sw_rate;
		logic [15:0] input_turn_on_threshold;
		logic [15:0] input_turn_off_threshold;
		logic [15:0] spread;
		logic [15:0] cur_offset;
		logic [15:0] ov_level;
		logic [15:0] rdata;
		logic done;
		logic unsupported;
		conv_state_e conv;
		logic warn;
		logic ov;
		logic signed [31:0] setpoint;
		logic [31:0] ramp_acc;
		logic signed [31:0] vref;
		logic signed [31:0] iout_rep;
		logic [19:0] period;
		logic [19:0] on_time;
		logic [19:0] phase;
	} bank_s;

	bank_s r_reg;
	bank_s r_next;

	// ==================================================================
	// number formats
	function automatic logic signed [31:0] fix_shift(
		input logic signed [31:0] v,
		input int sh
	);
		if (sh >= 0) begin
			fix_shift = v <<< sh;
		end else begin
			fix_shift = v >>> (-sh);
		end
	endfunction : fix_shift

	function automatic logic signed [31:0] lin_to_fix(
		input logic [15:0] w
	);
		logic signed [4:0] e;
		logic signed [10:0] m;
		e = w[LIN_EXP_HI:LIN_EXP_LO];
		m = w[LIN_MAN_HI:LIN_MAN_LO];
		lin_to_fix = fix_shift(32'(m), int'(e) + FIX_FRAC);
	endfunction : lin_to_fix

	// non-linear modes fall back to the fixed exponent
	function automatic logic signed [31:0] vout_to_fix(
		input logic [15:0] w,
		input logic [7:0] mode,
		input logic is_signed
	);
		logic signed [4:0] e;
		logic signed [31:0] m;
		int sh;
		e = mode[MODE_EXP_HI:MODE_EXP_LO];
		m = is_signed ? 32'(signed'(w)) : signed'({16'h0000, w});
		if (mode[MODE_SEL_HI:MODE_SEL_LO] == MODE_LINEAR) begin
			sh = int'(e) + FIX_FRAC;
		end else begin
			sh = VOUT_EXP_FIXED + FIX_FRAC;
		end
		vout_to_fix = fix_shift(m, sh);
	endfunction : vout_to_fix

	// ==================================================================
	// next state
	always_comb begin
		logic signed [31:0] floor_v;
		logic signed [31:0] base_v;
		logic signed [31:0] req_v;
		logic signed [31:0] tgt_v;
		logic signed [31:0] vin_v;
		logic signed [31:0] iout_v;
		logic signed [31:0] dmax_v;
		logic signed [31:0] duty_v;
		logic signed [31:0] freq_v;
		logic signed [63:0] drop_mv;
		logic signed [63:0] drop_v;
		logic [31:0] acc_sum;
		logic [63:0] on_wide;
		logic [3:0] units;
		logic [19:0] per;
		logic step;
		floor_v = '0;
		base_v = '0;
		req_v = '0;
		tgt_v = '0;
		vin_v = '0;
		iout_v = '0;
		dmax_v = '0;
		duty_v = '0;
		freq_v = '0;
		drop_mv = '0;
		drop_v = '0;
		acc_sum = '0;
		on_wide = '0;
		units = '0;
		per = '0;
		step = 1'b0;
		r_next = r_reg;
		r_next.done = 1'b0;
		r_next.unsupported = 1'b0;

		// command port
		if (cmd_valid_i) begin
			r_next.done = 1'b1;
			unique case (cmd_code_i)
			CODE_MARGIN_DOWN: begin
				if (cmd_write_i) r_next.margin_down = cmd_wdata_i;
				r_next.rdata = r_reg.margin_down;
			end
			CODE_RAMP_RATE: begin
				if (cmd_write_i) r_next.ramp_rate = cmd_wdata_i;
				r_next.rdata = r_reg.ramp_rate;
			end
			CODE_SLOPE: begin
				if (cmd_write_i) r_next.slope = cmd_wdata_i;
				r_next.rdata = r_reg.slope;
			end
			CODE_FLOOR: begin
				if (cmd_write_i) r_next.floor = cmd_wdata_i;
				r_next.rdata = r_reg.floor;
			end
			CODE_DUTY_MAX: begin
				if (cmd_write_i) r_next.duty_max = cmd_wdata_i;
				r_next.rdata = r_reg.duty_max;
			end
			CODE_SW_RATE: begin
				if (cmd_write_i) r_next.sw_rate = cmd_wdata_i;
				r_next.rdata = r_reg.sw_rate;
			end
			CODE_INPUT_TURN_ON_THRESHOLD: begin
				if (cmd_write_i) r_next.input_turn_on_threshold = cmd_wdata_i;
				r_next.rdata = r_reg.input_turn_on_threshold;
			end
			CODE_INPUT_TURN_OFF_THRESHOLD: begin
				if (cmd_write_i) r_next.input_turn_off_threshold = cmd_wdata_i;
				r_next.rdata = r_reg.input_turn_off_threshold;
			end
			CODE_SPREAD: begin
				if (cmd_write_i) r_next.spread = cmd_wdata_i;
				r_next.rdata = r_reg.spread;
			end
			CODE_CUR_OFFSET: begin
				if (cmd_write_i) r_next.cur_offset = cmd_wdata_i;
				r_next.rdata = r_reg.cur_offset;
			end
			CODE_OV_LEVEL: begin
				if (cmd_write_i) r_next.ov_level = cmd_wdata_i;
				r_next.rdata = r_reg.ov_level;
			end
			default: begin
				r_next.done = 1'b0;
				r_next.unsupported = 1'b1;
				r_next.rdata = RESET_WORD;
			end
			endcase
		end

		// target selection, trim and floor
		floor_v = vout_to_fix(r_reg.floor, vout_mode_i, 1'b0);
		unique case (target_sel_i)
		TGT_HIGH: base_v = vout_to_fix(margin_up_target_i, vout_mode_i, 1'b0);
		TGT_LOW: base_v = vout_to_fix(r_reg.margin_down, vout_mode_i, 1'b0);
		default: base_v = vout_to_fix(vout_command_i, vout_mode_i, 1'b0);
		endcase
		req_v = base_v + vout_to_fix(vout_trim_i, vout_mode_i, 1'b1);
		tgt_v = (req_v < floor_v) ? floor_v : req_v;
		// set beats clear; warning only, no shutdown
		if (req_v < floor_v) begin
			r_next.warn = 1'b1;
		end else if (clear_warning_i) begin
			r_next.warn = 1'b0;
		end

		// input undervoltage lockout
		vin_v = lin_to_fix(vin_meas_i);
		unique case (r_reg.conv)
		CONV_IDLE: begin
			if (vin_v >= lin_to_fix(r_reg.input_turn_on_threshold)) r_next.conv = CONV_RUN;
		end
		CONV_RUN: begin
			if (vin_v <= lin_to_fix(r_reg.input_turn_off_threshold)) r_next.conv = CONV_IDLE;
		end
		default: r_next.conv = CONV_IDLE;
		endcase

		// ramp: rate in lsb per ms, one lsb step per overflow
		if (r_reg.conv != CONV_RUN) begin
			r_next.setpoint = '0;
			r_next.ramp_acc = '0;
		end else if (lin_to_fix(r_reg.ramp_rate) <= 0) begin
			r_next.setpoint = tgt_v;
			r_next.ramp_acc = '0;
		end else if (r_reg.setpoint == tgt_v) begin
			r_next.ramp_acc = '0;
		end else begin
			acc_sum = r_reg.ramp_acc + 32'(lin_to_fix(r_reg.ramp_rate));
			step = acc_sum >= 32'(CYCLES_PER_MS_P);
			r_next.ramp_acc = step ? acc_sum - 32'(CYCLES_PER_MS_P) : acc_sum;
			if (step && r_reg.setpoint < tgt_v) begin
				r_next.setpoint = r_reg.setpoint + 32'sd1;
			end else if (step) begin
				r_next.setpoint = r_reg.setpoint - 32'sd1;
			end
		end

		// load line: slope in mV/A times current, scaled to volts
		iout_v = lin_to_fix(iout_meas_i);
		drop_mv = (64'(lin_to_fix(r_reg.slope)) * 64'(iout_v)) >>> FIX_FRAC;
		drop_v = (drop_mv * 64'(MV_RECIP)) >>> MV_RECIP_SH;
		r_next.vref = r_reg.setpoint - 32'(drop_v);
		r_next.iout_rep = iout_v + lin_to_fix(r_reg.cur_offset);
		r_next.ov = vout_to_fix(vout_meas_i, vout_mode_i, 1'b0) >
			vout_to_fix(r_reg.ov_level, vout_mode_i, 1'b0);

		// switching timing in clock cycles
		freq_v = lin_to_fix(r_reg.sw_rate) >>> FIX_FRAC;
		per = (freq_v > 0) ? PER_W'(CLK_KHZ / freq_v) : '0;
		r_next.period = per;
		dmax_v = lin_to_fix(r_reg.duty_max);
		duty_v = lin_to_fix(duty_cmd_i);
		if (duty_v > dmax_v) duty_v = dmax_v;
		if (duty_v < 0) duty_v = '0;
		on_wide = (64'(per) * 64'(duty_v)) / 64'(PCT_FULL << FIX_FRAC);
		r_next.on_time = PER_W'(on_wide);
		units = r_reg.spread[COUNT_HI:COUNT_LO];
		if (units == '0) units = COUNT_ONE;
		r_next.phase = PER_W'((64'(per) *
			64'(r_reg.spread[POS_HI:POS_LO])) / 64'(units));
	end

	// ==================================================================
	// registers
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			r_reg <= '0;
			r_reg.conv <= CONV_IDLE;
			r_reg.margin_down <= RESET_WORD;
			r_reg.floor <= RESET_WORD;
			r_reg.ov_level <= RESET_WORD;
		end else begin
			r_reg <= r_next;
		end
	end

	// ==================================================================
	// phase generator
	pwm_if pif();

	assign pif.period = r_reg.period;
	assign pif.on_time = r_reg.on_time;
	assign pif.phase = r_reg.phase;
	assign pif.run = (r_reg.conv == CONV_RUN);
	assign pif.lead = (r_reg.spread[POS_HI:POS_LO] == POS_LEAD);

	pwm_gen u_gen (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.ctl(pif.gen),
		.sync_i(sync_i),
		.pwm_o(pwm_o),
		.sync_out_o(sync_out_o)
	);

	// ==================================================================
	// outputs
	assign cmd_rdata_o = r_reg.rdata;
	assign cmd_done_o = r_reg.done;
	assign cmd_unsupported_o = r_reg.unsupported;
	assign vout_ref_o = r_reg.vref;
	assign iout_report_o = r_reg.iout_rep;
	assign floor_warning_o = r_reg.warn;
	assign ov_fault_o = r_reg.ov;
	assign converting_o = (r_reg.conv == CONV_RUN);
	assign group_id_o = r_reg.spread[GROUP_HI:GROUP_LO];
endmodule : pmbus_output_config_commands
`default_nettype wire

// ---- sim/pmbus_cfg_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
// ====
// shadow bank and checks
module pmbus_cfg_checker (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	input wire logic [15:0] cmd_rdata_o,
	input wire logic cmd_done_o,
	input wire logic cmd_unsupported_o,
	input wire logic [15:0] vout_command_i,
	input wire logic [15:0] vout_trim_i,
	input wire logic [15:0] margin_up_target_i,
	input wire logic [1:0] target_sel_i,
	input wire logic [15:0] vin_meas_i,
	input wire logic [15:0] iout_meas_i,
	input wire logic [15:0] vout_meas_i,
	input wire logic clear_warning_i,
	input wire logic signed [31:0] iout_report_o,
	input wire logic floor_warning_o,
	input wire logic ov_fault_o,
	input wire logic converting_o,
	input wire logic [3:0] group_id_o,
	input wire logic sync_out_o
);
	logic [15:0] sh [256];
	logic [15:0] rd_reg;
	logic over_reg;
	logic signed [31:0] irep_reg;
	logic [15:0] tgt;
	logic below;

	function automatic logic known(input logic [7:0] c);
		return c inside {8'h26, 8'h27, 8'h28, 8'h2B, 8'h32, 8'h33, 8'h35,
			8'h36, 8'h37, 8'h39, 8'h40};
	endfunction : known

	// linear word to units times 2^11
	function automatic logic signed [31:0] lin(input logic [15:0] w);
		logic signed [31:0] m;
		int e;
		m = 32'($signed(w[10:0]));
		e = int'($signed(w[15:11])) + 11;
		return (e < 0) ? (m >>> -e) : (m <<< e);
	endfunction : lin

	assign tgt = (target_sel_i == 2'h1) ? margin_up_target_i :
		(target_sel_i == 2'h2) ? sh[8'h26] : vout_command_i;
	assign below = $signed({2'b00, tgt}) + $signed({{2{vout_trim_i[15]}},
		vout_trim_i}) < $signed({2'b00, sh[8'h2B]});

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < 256; i++) begin
				sh[i] <= 16'h0000;
			end
			rd_reg <= 16'h0000;
			over_reg <= 1'b0;
			irep_reg <= '0;
		end else begin
			if (cmd_valid_i && cmd_write_i && known(cmd_code_i)) begin
				sh[cmd_code_i] <= cmd_wdata_i;
			end
			rd_reg <= sh[cmd_code_i];
			over_reg <= vout_meas_i > sh[8'h40];
			irep_reg <= lin(iout_meas_i) + lin(sh[8'h39]);
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	AST_READ_BACK: assert property (cmd_valid_i && known(cmd_code_i)
		|=> cmd_done_o && cmd_rdata_o == rd_reg) else $error("word mismatch");
	AST_REFUSE: assert property (cmd_valid_i && !known(cmd_code_i)
		|=> cmd_unsupported_o && !cmd_done_o && cmd_rdata_o == 16'h0000)
		else $error("unmapped code not refused");
	AST_QUIET: assert property (!cmd_valid_i
		|=> !cmd_done_o && !cmd_unsupported_o) else $error("stray answer");
	AST_FLOOR_WARN: assert property (below |=> floor_warning_o)
		else $error("floor warning missing");
	AST_WARN_HOLD: assert property (floor_warning_o && !clear_warning_i
		|=> floor_warning_o) else $error("warning dropped");
	AST_OV_LEVEL: assert property (ov_fault_o == over_reg)
		else $error("over-voltage flag wrong");
	AST_TURN_ON: assert property (!converting_o
		&& lin(vin_meas_i) >= lin(sh[8'h35]) |=> converting_o)
		else $error("no start");
	AST_TURN_OFF: assert property (converting_o
		&& lin(vin_meas_i) <= lin(sh[8'h36]) |=> !converting_o)
		else $error("no stop");
	AST_CUR_OFFSET: assert property (iout_report_o == irep_reg)
		else $error("current report wrong");
	AST_GROUP: assert property (group_id_o == sh[8'h37][11:8])
		else $error("group id wrong");
	AST_SYNC_LEAD: assert property (sync_out_o
		|-> $past(sh[8'h37][3:0]) == 4'h0) else $error("sync from follower");

	cover property (cmd_valid_i && !known(cmd_code_i));
	cover property (floor_warning_o && !clear_warning_i);
	cover property ($rose(converting_o));
	cover property (sync_out_o);
endmodule : pmbus_cfg_checker
`default_nettype wire

// ---- sim/pmbus_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ====
// host side of the command port
module pmbus_host_model (
	input wire logic core_clk_i,
	output logic cmd_valid_o,
	output logic cmd_write_o,
	output logic [7:0] cmd_code_o,
	output logic [15:0] cmd_wdata_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_wdata_o = 16'h0000;
	end

	// one whole word, held until the taking edge; limits go first
	task automatic xfer(input logic wr, input logic [7:0] c,
		input logic [15:0] d);
		cmd_valid_o = 1'b1;
		cmd_write_o = wr;
		cmd_code_o = c;
		cmd_wdata_o = d;
		@(posedge core_clk_i);
		#1;
	endtask : xfer

	// released data no longer shows the last word
	task automatic idle();
		cmd_valid_o = 1'b0;
		cmd_wdata_o = ~cmd_wdata_o;
	endtask : idle
endmodule : pmbus_host_model
`default_nettype wire

// ---- sim/pmbus_output_config_commands_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ====
// bench top
module pmbus_output_config_commands_tb;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic cmd_valid_i, cmd_write_i, clear_warning_i, sync_i;
	logic cmd_done_o, cmd_unsupported_o, floor_warning_o, ov_fault_o;
	logic converting_o, pwm_o, sync_out_o;
	logic [1:0] target_sel_i;
	logic [3:0] group_id_o;
	logic [7:0] cmd_code_i, vout_mode_i;
	logic [15:0] cmd_wdata_i, cmd_rdata_o, vout_command_i, vout_trim_i;
	logic [15:0] margin_up_target_i, vin_meas_i, iout_meas_i, vout_meas_i;
	logic [15:0] duty_cmd_i, w;
	logic signed [31:0] vout_ref_o, iout_report_o;
	logic [15:0] mdl [256] = '{default: 16'h0000};
	logic [7:0] codes [11] = '{8'h26, 8'h27, 8'h28, 8'h2B, 8'h32, 8'h33,
		8'h35, 8'h36, 8'h37, 8'h39, 8'h40};
	logic [23:0] cfg [11] = '{24'h2B0800, 24'h401000, 24'h350010, 24'h36000A,
		24'h270000, 24'h280000, 24'h260400, 24'h32001E, 24'h3303E8,
		24'h370310, 24'h390003};
	logic [16:0] vs [6] = '{17'h00000, 17'h0001E, 17'h00021, 17'h00017,
		17'h00014, 17'h00021};
	logic [15:0] tg [4] = '{16'h1000, 16'h0600, 16'h0400, 16'h1000};
	logic [16:0] exp_q [$];
	int num_errors = 0;
	int tests_run = 0;
	int hi;
	int syn;

	always #5 core_clk_i = ~core_clk_i;

	pmbus_output_config_commands #(.CYCLES_PER_MS_P(100))
		i_pmbus_output_config_commands (
		.core_clk_i, .rst_b_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i,
		.cmd_wdata_i, .cmd_rdata_o, .cmd_done_o, .cmd_unsupported_o,
		.vout_mode_i, .vout_command_i, .vout_trim_i, .margin_up_target_i,
		.target_sel_i, .vin_meas_i, .iout_meas_i, .vout_meas_i, .duty_cmd_i,
		.clear_warning_i, .sync_i, .vout_ref_o, .iout_report_o,
		.floor_warning_o, .ov_fault_o, .converting_o, .group_id_o, .pwm_o,
		.sync_out_o);
	pmbus_host_model i_pmbus_host_model (.core_clk_i,
		.cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
		.cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask : chk

	task automatic wrap_up();
		if (exp_q.size() != 0) num_errors++;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : step

	// note the old word (or a refusal), then send
	task automatic op(input logic wr, input logic [7:0] c,
		input logic [15:0] d);
		logic k;
		k = 1'b0;
		foreach (codes[i]) if (codes[i] == c) k = 1'b1;
		exp_q.push_back(k ? {1'b0, mdl[c]} : 17'h10000);
		if (wr && k) mdl[c] = d;
		i_pmbus_host_model.xfer(wr, c, d);
	endtask : op

	always @(posedge core_clk_i) begin
		if (rst_b_i && (cmd_done_o || cmd_unsupported_o)) begin
			chk("pending", 32'h1, 32'(exp_q.size() > 0));
			if (exp_q.size() > 0) begin
				chk("answer", 32'(exp_q.pop_front()),
					{15'h0, cmd_unsupported_o, cmd_rdata_o});
			end
		end
	end

	initial begin
		{sync_i, clear_warning_i, target_sel_i} = 4'h4;
		vout_mode_i = 8'h15;
		vout_command_i = 16'h1000;
		vout_trim_i = 16'h0000;
		margin_up_target_i = 16'h0600;
		{vin_meas_i, iout_meas_i, vout_meas_i} = '0;
		duty_cmd_i = 16'h0050;
		void'($urandom(76));
		step(6);
		rst_b_i = 1'b1;
		foreach (codes[i]) begin
			w = {5'h00, 11'($urandom)};
			op(1'b1, codes[i], w);
			op(1'b0, codes[i], 16'h0000);
			if (i % 2 == 1) begin
				i_pmbus_host_model.idle();
				step(1);
			end
		end
		op(1'b0, 8'h29, 16'h0000);
		op(1'b1, 8'h41, 16'hFFFF);
		op(1'b0, 8'h41, 16'h0000);
		foreach (cfg[i]) op(1'b1, cfg[i][23:16], cfg[i][15:0]);
		i_pmbus_host_model.idle();
		step(3);
		foreach (vs[i]) begin
			vin_meas_i = vs[i][16:1];
			step(2);
			chk("converting", 32'(vs[i][0]), 32'(converting_o));
		end
		foreach (tg[i]) begin
			target_sel_i = 2'(i);
			step(4);
			chk("warning", 32'(tg[i] < 16'h0800), 32'(floor_warning_o));
			chk("reference", (tg[i] < 16'h0800) ? 32'h800 : 32'(tg[i]),
				vout_ref_o);
			chk("fault", 32'h0, 32'(ov_fault_o));
		end
		target_sel_i = 2'h2;
		step(2);
		clear_warning_i = 1'b0;
		target_sel_i = 2'h0;
		step(3);
		chk("held warning", 32'h1, 32'(floor_warning_o));
		clear_warning_i = 1'b1;
		step(2);
		chk("cleared warning", 32'h0, 32'(floor_warning_o));
		vout_mode_i = 8'h16;
		step(4);
		chk("mode scale", 32'h2000, vout_ref_o);
		vout_mode_i = 8'h40;
		step(4);
		chk("mode fallback", 32'h1000, vout_ref_o);
		vout_mode_i = 8'h15;
		vout_meas_i = 16'h1001;
		step(2);
		chk("overvoltage", 32'h1, 32'(ov_fault_o));
		vout_meas_i = 16'h1000;
		step(2);
		chk("overvoltage", 32'h0, 32'(ov_fault_o));
		repeat (4) begin
			iout_meas_i = {5'h00, 11'($urandom)};
			step(2);
			chk("current", (32'($signed(iout_meas_i[10:0])) + 32'sd3) <<< 11,
				iout_report_o);
		end
		// 50 lsb per ms of 100 cycles: one lsb every second cycle
		op(1'b1, 8'h27, 16'hA832);
		i_pmbus_host_model.idle();
		step(3);
		vout_command_i = 16'h1010;
		step(21);
		chk("ramp midway", 32'h100A, vout_ref_o);
		step(20);
		chk("ramp end", 32'h1010, vout_ref_o);
		// 1000 mV/A at 1 A drops one volt
		iout_meas_i = 16'h0001;
		op(1'b1, 8'h28, 16'h03E8);
		i_pmbus_host_model.idle();
		step(4);
		chk("droop", 32'h0810, vout_ref_o);
		hi = 0;
		syn = 0;
		step(20);
		repeat (100) begin
			hi += int'(pwm_o);
			syn += int'(sync_out_o);
			step(1);
		end
		chk("on cycles", 32'd30, 32'(hi));
		chk("sync pulses", 32'd1, 32'(syn));
		chk("group", 32'h3, 32'(group_id_o));
		// follower at position 1 of 4: period starts 25 cycles after sync
		op(1'b1, 8'h37, 16'h0341);
		i_pmbus_host_model.idle();
		step(3);
		sync_i = 1'b1;
		step(1);
		sync_i = 1'b0;
		hi = 0;
		syn = 0;
		while (!pwm_o && hi < 100) begin
			syn += int'(sync_out_o);
			step(1);
			hi++;
		end
		chk("phase delay", 32'd25, 32'(hi));
		chk("follower sync", 32'd0, 32'(syn));
		wrap_up();
	end

	initial begin
		#300000;
		num_errors++;
		wrap_up();
	end
endmodule : pmbus_output_config_commands_tb

bind pmbus_output_config_commands pmbus_cfg_checker i_pmbus_cfg_checker (
	.core_clk_i, .rst_b_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i,
	.cmd_wdata_i, .cmd_rdata_o, .cmd_done_o, .cmd_unsupported_o,
	.vout_command_i, .vout_trim_i, .margin_up_target_i, .target_sel_i,
	.vin_meas_i, .iout_meas_i, .vout_meas_i, .clear_warning_i,
	.iout_report_o, .floor_warning_o, .ov_fault_o, .converting_o,
	.group_id_o, .sync_out_o);
`default_nettype wire
